// >>> hw/half_bridge_fault_logic.sv
// Fault sequencing and output gating of a half-bridge gate driver
`timescale 1ns/1ps
// Operation
// - Both commands on together force both gates off.
// - High side desaturation while on: soft turn-off, sync line held low.
// - After soft shutdown, pull fault line low: hard shutdown of both.
// - During soft shutdown the other output ignores its command.
// - Fault clear releases a self-latched fault; outputs follow commands.
// - High side desat sense ignored while high gate is off.
// - Low side follows the same desaturation sequence.
// - Low side desat sense ignored while low gate is off.
// - Sync line held low externally freezes both outputs.
// - Fault line pulled low externally forces both outputs off.
// - Fault clear cannot cancel an externally held fault line.
// - External fault release resumes following commands.
// - Desat fault keeps fault line latched low until fault clear.
// - Supply undervoltage holds fault line low, not latched.
// - Soft shutdown tristates normal drive and enables the soft pull-down.
// - Desat detection stays active and overrides freeze.
module half_bridge_fault_logic (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      reset,
	// Controller commands
	input  wire logic                      high_side_command,
	input  wire logic                      low_side_command,
	input  wire logic                      fault_clear,
	// Sense inputs
	input  wire logic                      high_desat_sense,
	input  wire logic                      low_desat_sense,
	input  wire logic                      undervoltage,
	// Shared open-drain lines: levels seen on the wire, own output level and enable
	input  wire logic                      sync_freeze_n_in,
	input  wire logic                      fault_shutdown_n_in,
	output hb_fault_pkg::od_line_t         sync_freeze_n,
	output hb_fault_pkg::od_line_t         fault_shutdown_n,
	// Gate outputs
	output hb_fault_pkg::gate_drive_t      high_gate_out,
	output hb_fault_pkg::gate_drive_t      low_gate_out
);
	hb_fault_pkg::fault_state_t state;
	logic                       soft_start;
	logic                       soft_done;
	logic                       high_on;
	logic                       low_on;
	logic                       high_desat;
	logic                       low_desat;
	logic                       ext_freeze;
	logic                       ext_shutdown;
	logic                       next_high;
	logic                       next_low;

	////////////////////////////////////////////////////////////////////////
	soft_timer #(
		.DURATION(hb_fault_pkg::SOFT_SHUTDOWN_CYCLES)
	) i_soft_timer (
		.ref_clk(ref_clk),
		.reset  (reset),
		.start  (soft_start),
		.done   (soft_done)
	);

	assign high_on = high_gate_out.drive & high_gate_out.drive_en;
	assign low_on  = low_gate_out.drive & low_gate_out.drive_en;
	assign high_desat = high_desat_sense & high_on;
	assign low_desat  = low_desat_sense & low_on;
	// Own pull-downs are excluded so that the device does not freeze itself
	assign ext_freeze   = ~sync_freeze_n_in & ~sync_freeze_n.oe;
	assign ext_shutdown = ~fault_shutdown_n_in & ~fault_shutdown_n.oe;
	assign soft_start = (state == hb_fault_pkg::ST_RUN) & (high_desat | low_desat);

	////////////////////////////////////////////////////////////////////////
	// Fault sequence
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= hb_fault_pkg::ST_RUN;
		end else begin
			case (state)
				hb_fault_pkg::ST_RUN: begin
					// Desat wins over freeze and external shutdown
					if (high_desat) begin
						state <= hb_fault_pkg::ST_SOFT_HIGH;
					end else if (low_desat) begin
						state <= hb_fault_pkg::ST_SOFT_LOW;
					end
				end
				hb_fault_pkg::ST_SOFT_HIGH, hb_fault_pkg::ST_SOFT_LOW: begin
					if (soft_done) begin
						state <= hb_fault_pkg::ST_LATCHED;
					end
				end
				hb_fault_pkg::ST_LATCHED: begin
					if (fault_clear) begin
						state <= hb_fault_pkg::ST_RUN;
					end
				end
				default: begin
					state <= hb_fault_pkg::ST_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gate command resolution
	always_comb begin
		next_high = high_gate_out.drive;
		next_low  = low_gate_out.drive;
		case (state)
			hb_fault_pkg::ST_RUN: begin
				if (soft_start) begin
					next_high = high_desat ? 1'b0 : high_gate_out.drive;
					next_low  = low_desat & ~high_desat ? 1'b0 : low_gate_out.drive;
				end else if (ext_shutdown | undervoltage) begin
					next_high = 1'b0;
					next_low  = 1'b0;
				end else if (ext_freeze) begin
					next_high = high_gate_out.drive;
					next_low  = low_gate_out.drive;
				end else if (high_side_command & low_side_command) begin
					next_high = 1'b0;
					next_low  = 1'b0;
				end else begin
					next_high = high_side_command;
					next_low  = low_side_command;
				end
			end
			hb_fault_pkg::ST_SOFT_HIGH: begin
				next_high = 1'b0;
				next_low  = low_gate_out.drive;
			end
			hb_fault_pkg::ST_SOFT_LOW: begin
				next_high = high_gate_out.drive;
				next_low  = 1'b0;
			end
			hb_fault_pkg::ST_LATCHED: begin
				next_high = 1'b0;
				next_low  = 1'b0;
			end
			default: begin
				next_high = 1'b0;
				next_low  = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Gate outputs
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			high_gate_out <= '{drive: hb_fault_pkg::GATE_RESET, drive_en: 1'b1, soft_pulldown: 1'b0};
			low_gate_out  <= '{drive: hb_fault_pkg::GATE_RESET, drive_en: 1'b1, soft_pulldown: 1'b0};
		end else begin
			high_gate_out.drive <= next_high;
			low_gate_out.drive  <= next_low;
			high_gate_out.drive_en      <= ~(soft_start & high_desat) & ~(state == hb_fault_pkg::ST_SOFT_HIGH & ~soft_done);
			high_gate_out.soft_pulldown <= (soft_start & high_desat) | (state == hb_fault_pkg::ST_SOFT_HIGH & ~soft_done);
			low_gate_out.drive_en      <= ~(soft_start & low_desat & ~high_desat) & ~(state == hb_fault_pkg::ST_SOFT_LOW & ~soft_done);
			low_gate_out.soft_pulldown <= (soft_start & low_desat & ~high_desat) | (state == hb_fault_pkg::ST_SOFT_LOW & ~soft_done);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain network lines: out is always low, only the enable moves
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sync_freeze_n    <= '{out: 1'b0, oe: 1'b0};
			fault_shutdown_n <= '{out: 1'b0, oe: 1'b0};
		end else begin
			sync_freeze_n.out    <= 1'b0;
			fault_shutdown_n.out <= 1'b0;
			sync_freeze_n.oe <= soft_start | ((state == hb_fault_pkg::ST_SOFT_HIGH | state == hb_fault_pkg::ST_SOFT_LOW) & ~soft_done);
			fault_shutdown_n.oe <= (state == hb_fault_pkg::ST_LATCHED & ~fault_clear) | soft_done | (undervoltage & state == hb_fault_pkg::ST_RUN & ~soft_start);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_shoot_through: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_RUN && !soft_start && !ext_shutdown && !undervoltage && !ext_freeze
		 && high_side_command && low_side_command) |=> (!high_gate_out.drive && !low_gate_out.drive))
		else $error("both gates not forced off");
	a_soft_sync_low: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_SOFT_HIGH && !soft_done) |=> sync_freeze_n.oe)
		else $error("sync line released during soft shutdown");
	a_hard_after_soft: assert property (@(posedge ref_clk) disable iff (reset)
		soft_done |=> (fault_shutdown_n.oe && !sync_freeze_n.oe && state == hb_fault_pkg::ST_LATCHED))
		else $error("fault line not pulled after soft shutdown");
	a_freeze_other: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_SOFT_HIGH) |=> $stable(low_gate_out.drive))
		else $error("low gate changed during high side soft shutdown");
	a_clear_resumes: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_LATCHED && fault_clear) |=> (state == hb_fault_pkg::ST_RUN))
		else $error("fault clear did not release latch");
	a_desat_high_off: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_RUN && !high_on && !low_desat) |=> (state == hb_fault_pkg::ST_RUN))
		else $error("desat raised with gate off");
	a_soft_low_seq: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_SOFT_LOW && !soft_done) |=> (sync_freeze_n.oe && low_gate_out.soft_pulldown))
		else $error("low side soft shutdown incomplete");
	a_ext_freeze: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_RUN && ext_freeze && !soft_start && !ext_shutdown && !undervoltage)
		|=> ($stable(high_gate_out.drive) && $stable(low_gate_out.drive)))
		else $error("outputs moved while frozen");
	a_ext_shutdown: assert property (@(posedge ref_clk) disable iff (reset)
		(state == hb_fault_pkg::ST_RUN && ext_shutdown && !soft_start) |=> (!high_gate_out.drive && !low_gate_out.drive))
		else $error("external shutdown ignored");
	a_soft_timing: assert property (@(posedge ref_clk) disable iff (reset)
		soft_start |-> ##[1:400] soft_done)
		else $error("soft shutdown did not end in time");
	c_high_desat: cover property (@(posedge ref_clk) disable iff (reset) state == hb_fault_pkg::ST_SOFT_HIGH);
	c_low_desat: cover property (@(posedge ref_clk) disable iff (reset) state == hb_fault_pkg::ST_SOFT_LOW);
	c_clear: cover property (@(posedge ref_clk) disable iff (reset) state == hb_fault_pkg::ST_LATCHED && fault_clear);
	c_ext_shut: cover property (@(posedge ref_clk) disable iff (reset) ext_shutdown && high_side_command);
endmodule : half_bridge_fault_logic

// >>> include/hb_fault_pkg.sv
// Package: constants and carrier types for the half-bridge fault logic
package hb_fault_pkg;
	// Soft shutdown duration, in ns, and derived cycle count at 40 MHz
	localparam int          SOFT_SHUTDOWN_NS     = 9250;
	localparam int          CLK_PERIOD_NS        = 25;
	localparam int          SOFT_SHUTDOWN_CYCLES = (SOFT_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W                = 16;
	localparam logic [15:0] CNT_RESET            = 16'h0000;
	localparam logic        GATE_RESET           = 1'b0;

	typedef enum {
		ST_RUN,
		ST_SOFT_HIGH,
		ST_SOFT_LOW,
		ST_LATCHED
	} fault_state_t;

	// Gate drive of one side: normal drive, output enable, soft pull-down
	typedef struct packed {
		logic drive;
		logic drive_en;
		logic soft_pulldown;
	} gate_drive_t;

	// Shared open-drain line: output level, output enable
	typedef struct packed {
		logic out;
		logic oe;
	} od_line_t;
endpackage : hb_fault_pkg

// >>> hw/soft_timer.sv
// Soft shutdown duration timer
`timescale 1ns/1ps
module soft_timer #(
	parameter int DURATION = hb_fault_pkg::SOFT_SHUTDOWN_CYCLES
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// Control
	input  wire logic start,
	output logic      done
);
	logic [hb_fault_pkg::CNT_W-1:0] count;
	logic                           running;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count <= hb_fault_pkg::CNT_RESET;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= hb_fault_pkg::CNT_RESET;
				running <= 1'b1;
			end else if (running) begin
				if (count == hb_fault_pkg::CNT_W'(DURATION - 2)) begin
					running <= 1'b0;
					done <= 1'b1;
				end
				count <= count + 1'b1;
			end
		end
	end
endmodule : soft_timer

// >>> sim/fault_net_peer.sv
// Controller and peer drivers sharing the wired-AND sync and fault lines
`timescale 1ns/1ps
module fault_net_peer (
	// Device pull-downs
	input  wire logic dev_sync_oe,
	input  wire logic dev_fault_oe,
	// Pull-downs of the other parties
	input  wire logic peer_sync_pull,
	input  wire logic peer_fault_pull,
	// Resolved wire levels
	output logic      sync_level_n,
	output logic      fault_level_n
);
	// Pull-up holds each line high unless some party pulls it low
	assign sync_level_n  = !(dev_sync_oe || peer_sync_pull);
	assign fault_level_n = !(dev_fault_oe || peer_fault_pull);
endmodule : fault_net_peer

// >>> sim/tb_half_bridge_fault_logic.sv
// Self-checking testbench of the half-bridge fault logic
`timescale 1ns/1ps
module tb_half_bridge_fault_logic;
	localparam hb_fault_pkg::gate_drive_t G_ON   = 3'h6;
	localparam hb_fault_pkg::gate_drive_t G_OFF  = 3'h2;
	localparam hb_fault_pkg::gate_drive_t G_SOFT = 3'h1;
	logic                        ref_clk             = 1'b0;
	logic                        reset               = 1'b1;
	logic                        high_side_command   = 1'b0;
	logic                        low_side_command    = 1'b0;
	logic                        fault_clear         = 1'b0;
	logic                        high_desat_sense    = 1'b0;
	logic                        low_desat_sense     = 1'b0;
	logic                        undervoltage        = 1'b0;
	logic                        peer_sync_pull      = 1'b0;
	logic                        peer_fault_pull     = 1'b0;
	logic                        sync_freeze_n_in;
	logic                        fault_shutdown_n_in;
	hb_fault_pkg::od_line_t      sync_freeze_n;
	hb_fault_pkg::od_line_t      fault_shutdown_n;
	hb_fault_pkg::gate_drive_t   high_gate_out;
	hb_fault_pkg::gate_drive_t   low_gate_out;
	int                          n_fail              = 0;
	int                          checks_done         = 0;

	half_bridge_fault_logic i_half_bridge_fault_logic (.ref_clk(ref_clk), .reset(reset),
		.high_side_command(high_side_command), .low_side_command(low_side_command), .fault_clear(fault_clear),
		.high_desat_sense(high_desat_sense), .low_desat_sense(low_desat_sense), .undervoltage(undervoltage),
		.sync_freeze_n_in(sync_freeze_n_in), .fault_shutdown_n_in(fault_shutdown_n_in),
		.sync_freeze_n(sync_freeze_n), .fault_shutdown_n(fault_shutdown_n),
		.high_gate_out(high_gate_out), .low_gate_out(low_gate_out));
	fault_net_peer i_fault_net_peer (.dev_sync_oe(sync_freeze_n.oe), .dev_fault_oe(fault_shutdown_n.oe),
		.peer_sync_pull(peer_sync_pull), .peer_fault_pull(peer_fault_pull),
		.sync_level_n(sync_freeze_n_in), .fault_level_n(fault_shutdown_n_in));

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : step
	task chk_gate(input hb_fault_pkg::gate_drive_t got, input hb_fault_pkg::gate_drive_t exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s gate %b, want %b", $time, what, got, exp);
		end
	endtask : chk_gate
	task chk_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s is %b, want %b", $time, what, got, exp);
		end
	endtask : chk_bit
	task give_verdict;
		$display("checks %0d, failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////////////
	task t_shoot;
		high_side_command = 1'b1;
		step(1);
		chk_gate(high_gate_out, G_ON, "high alone");
		low_side_command = 1'b1;
		step(1);
		chk_gate(high_gate_out, G_OFF, "high with both");
		chk_gate(low_gate_out, G_OFF, "low with both");
		high_side_command = 1'b0;
		step(1);
		chk_gate(low_gate_out, G_ON, "low alone");
		low_side_command = 1'b0;
		step(1);
	endtask : t_shoot
	task t_ignore;
		high_desat_sense = 1'b1;
		step(1);
		low_desat_sense = 1'b1;
		step(3);
		chk_bit(sync_freeze_n.oe, 1'b0, "sync with gates off");
		chk_bit(fault_shutdown_n.oe, 1'b0, "fault with gates off");
		high_desat_sense = 1'b0;
		low_desat_sense = 1'b0;
		step(1);
	endtask : t_ignore
	task t_desat(input logic hi);
		int i;
		high_side_command = hi;
		low_side_command = !hi;
		step(2);
		high_desat_sense = hi;
		low_desat_sense = !hi;
		step(1);
		chk_gate(hi ? high_gate_out : low_gate_out, G_SOFT, "soft side");
		chk_bit(sync_freeze_n.oe, 1'b1, "sync in soft");
		chk_bit(sync_freeze_n.out, 1'b0, "sync pulls low");
		// Only the frozen side's command rises, so anti-shoot-through cannot hide a missing freeze
		high_side_command = !hi;
		low_side_command = hi;
		step(2);
		chk_gate(hi ? low_gate_out : high_gate_out, G_OFF, "frozen side");
		chk_bit(sync_freeze_n.oe, 1'b1, "sync held in soft");
		high_side_command = hi;
		low_side_command = !hi;
		// Polling starts two cycles into the soft shutdown
		for (i = 0; i < 400 && fault_shutdown_n.oe !== 1'b1; i++)
			step(1);
		chk_bit(i == hb_fault_pkg::SOFT_SHUTDOWN_CYCLES - 2, 1'b1, "soft length");
		chk_bit(fault_shutdown_n.oe, 1'b1, "fault after soft");
		chk_bit(fault_shutdown_n.out, 1'b0, "fault pulls low");
		chk_bit(sync_freeze_n.oe, 1'b0, "sync after soft");
		high_desat_sense = 1'b0;
		low_desat_sense = 1'b0;
		step(3);
		chk_gate(hi ? high_gate_out : low_gate_out, G_OFF, "latched side");
		chk_bit(fault_shutdown_n.oe, 1'b1, "fault held");
		fault_clear = 1'b1;
		step(1);
		fault_clear = 1'b0;
		step(2);
		chk_gate(hi ? high_gate_out : low_gate_out, G_ON, "after clear");
		chk_bit(fault_shutdown_n.oe, 1'b0, "fault cleared");
		high_side_command = 1'b0;
		low_side_command = 1'b0;
		step(2);
	endtask : t_desat
	task t_freeze;
		high_side_command = 1'b1;
		step(2);
		peer_sync_pull = 1'b1;
		step(1);
		high_side_command = 1'b0;
		low_side_command = 1'b1;
		step(3);
		chk_gate(high_gate_out, G_ON, "frozen high");
		chk_gate(low_gate_out, G_OFF, "frozen low");
		// Desaturation while frozen must still start a soft shutdown
		high_desat_sense = 1'b1;
		step(1);
		chk_gate(high_gate_out, G_SOFT, "desat in freeze");
		chk_bit(sync_freeze_n.oe, 1'b1, "own sync in freeze");
		peer_sync_pull = 1'b0;
		high_desat_sense = 1'b0;
		low_side_command = 1'b0;
		step(hb_fault_pkg::SOFT_SHUTDOWN_CYCLES);
		chk_bit(fault_shutdown_n.oe, 1'b1, "fault after frozen soft");
		fault_clear = 1'b1;
		step(1);
		fault_clear = 1'b0;
		step(2);
		chk_gate(high_gate_out, G_OFF, "idle after clear");
	endtask : t_freeze
	task t_ext_sd;
		high_side_command = 1'b1;
		step(2);
		peer_fault_pull = 1'b1;
		step(2);
		chk_gate(high_gate_out, G_OFF, "external shutdown");
		fault_clear = 1'b1;
		step(2);
		fault_clear = 1'b0;
		chk_gate(high_gate_out, G_OFF, "clear refused");
		peer_fault_pull = 1'b0;
		step(3);
		chk_gate(high_gate_out, G_ON, "resumed");
		chk_bit(fault_shutdown_n.oe, 1'b0, "no own pull");
		high_side_command = 1'b0;
		undervoltage = 1'b1;
		step(2);
		chk_bit(fault_shutdown_n.oe, 1'b1, "undervoltage pull");
		undervoltage = 1'b0;
		step(2);
		chk_bit(fault_shutdown_n.oe, 1'b0, "undervoltage gone");
	endtask : t_ext_sd

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk);
		#2;
		reset = 1'b0;
		chk_gate(high_gate_out, G_OFF, "reset high");
		chk_gate(low_gate_out, G_OFF, "reset low");
		chk_bit(sync_freeze_n.oe, 1'b0, "reset sync");
		chk_bit(fault_shutdown_n.oe, 1'b0, "reset fault");
		t_shoot();
		t_ignore();
		t_desat(1'b1);
		t_desat(1'b0);
		t_freeze();
		t_ext_sd();
		give_verdict();
	end
	// Three soft shutdowns of 370 cycles dominate the run
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_fail++;
		give_verdict();
	end
endmodule : tb_half_bridge_fault_logic
